// File: rtl/nested_request_arbiter.sv
// Purpose: Picks the most urgent pending exception or request and presents its vector.
// Assumes: Inputs come from logic on clk_sys_in; priorities are driven by the core side.
// Notes: Grant is registered, so a late higher request replaces the offer next cycle.
//
// Summary of operation
// - Thirty maskable peripheral request channels besides core exceptions.
// - Each configurable request has a two-bit priority, four levels.
// - All interrupts and core exceptions are arbitrated here; late higher wins.
// - Tick calibration value reads 9000, one millisecond at 9 MHz.
// - Reset uses vector 0x4 at fixed priority -3, most urgent.
// - Non-maskable entry at 0x8, priority -2, raised by clock security monitor.
// - Hard fault at 0xC, fixed priority -1, for every fault.
// - Supervisor call 0x2C, deferred service 0x38, tick timer 0x3C.
// - Channel 0 watchdog at 0x40; channel 1 supply detector at 0x44.
// - Channel 2 carries real-time clock with event line 19, 0x48.
// - DMA channel 1 at 0x64, 2-3 at 0x68, 4-7 at 0x6C.
// - Channel 12 merges converter and comparator event lines, vector 0x70.
// - Timer one general events at 0x74, capture/compare at 0x78.
`timescale 1ns/1ps
`default_nettype none
module nested_request_arbiter
  import vector_map_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  input wire logic reset_entry_in,
  input wire logic clock_security_monitor_in,
  input wire logic fault_in,
  input wire core_req_s core_req_in,
  input wire logic [PRIO_W-1:0] supervisor_prio_in,
  input wire logic [PRIO_W-1:0] deferred_prio_in,
  input wire logic [PRIO_W-1:0] tick_prio_in,
  input wire logic [CHAN_COUNT-1:0] direct_req_in,
  input wire merged_src_s merged_in,
  input wire logic [CHAN_COUNT-1:0] chan_enable_in,
  input wire logic [CHAN_COUNT*PRIO_W-1:0] chan_prio_in,
  output logic grant_valid_out,
  output logic [RANK_W-1:0] grant_rank_out,
  output logic [31:0] grant_vector_out,
  output logic [15:0] tick_calibration_out
);
  logic [CHAN_COUNT-1:0] chan_req;
  logic [CHAN_COUNT-1:0] chan_pend;
  grant_s grant_reg;
  grant_s grant_next;
  grant_s best;

  request_merge u_merge (
    .direct_req_in(direct_req_in),
    .merged_in(merged_in),
    .chan_req_out(chan_req)
  );

  // Channels 30 and 31 are masked again here so a bad merge can never pend them.
  assign chan_pend = chan_req & chan_enable_in
      & {{(CHAN_COUNT-LIVE_CHANNELS){1'b0}}, {LIVE_CHANNELS{1'b1}}};

  function automatic logic [RANK_W-1:0] prog_rank(input logic [PRIO_W-1:0] p);
    prog_rank = RANK_PROG_BASE + {1'b0, p};
  endfunction : prog_rank

  // Strictly-less comparison while scanning upward keeps the lowest position on ties,
  // and core exceptions are scanned first because they sit ahead of every channel.
  always_comb begin
    best = '{valid: 1'b0, rank: RANK_IDLE, vector: VEC_NONE};
    if (core_req_in.supervisor_call_entry &&
        prog_rank(supervisor_prio_in) < best.rank) begin
      best = '{valid: 1'b1, rank: prog_rank(supervisor_prio_in), vector: VEC_SUPERVISOR};
    end
    if (core_req_in.deferred_service_entry &&
        prog_rank(deferred_prio_in) < best.rank) begin
      best = '{valid: 1'b1, rank: prog_rank(deferred_prio_in), vector: VEC_DEFERRED};
    end
    if (core_req_in.tick_timer_entry && prog_rank(tick_prio_in) < best.rank) begin
      best = '{valid: 1'b1, rank: prog_rank(tick_prio_in), vector: VEC_TICK};
    end
    for (int i = 0; i < LIVE_CHANNELS; i++) begin
      if (chan_pend[i] && prog_rank(chan_prio_in[i*PRIO_W +: PRIO_W]) < best.rank) begin
        best = '{valid: 1'b1, rank: prog_rank(chan_prio_in[i*PRIO_W +: PRIO_W]),
                 vector: chan_vector(5'(i))};
      end
    end
    if (fault_in) begin
      best = '{valid: 1'b1, rank: RANK_HARD_FAULT, vector: VEC_HARD_FAULT};
    end
    if (clock_security_monitor_in) begin
      best = '{valid: 1'b1, rank: RANK_NONMASK, vector: VEC_NONMASK};
    end
    if (reset_entry_in) begin
      best = '{valid: 1'b1, rank: RANK_RESET, vector: VEC_RESET};
    end
  end

  // Re-evaluated every cycle, so a higher request arriving late replaces the offer.
  always_comb begin
    grant_next = best;
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      grant_reg <= '{valid: 1'b0, rank: RANK_IDLE, vector: VEC_NONE};
    end else begin
      grant_reg <= grant_next;
    end
  end

  assign grant_valid_out = grant_reg.valid;
  assign grant_rank_out = grant_reg.rank;
  assign grant_vector_out = grant_reg.vector;
  assign tick_calibration_out = TICK_CALIBRATION;

  // Fixed entries override every programmable level and ignore the channel enables.
  a_reset_wins: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    reset_entry_in |=> grant_vector_out == VEC_RESET && grant_rank_out == RANK_RESET)
    else $error("Reset entry did not win arbitration.");
  a_nonmask_vec: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    clock_security_monitor_in && !reset_entry_in |=> grant_vector_out == VEC_NONMASK)
    else $error("Non-maskable entry not presented.");
  a_nonmask_rank: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    clock_security_monitor_in && !reset_entry_in
    |=> grant_valid_out && grant_rank_out == RANK_NONMASK)
    else $error("Non-maskable entry has the wrong rank.");
  a_fault_vec: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    fault_in && !clock_security_monitor_in && !reset_entry_in
    |=> grant_vector_out == VEC_HARD_FAULT && grant_rank_out == RANK_HARD_FAULT)
    else $error("Hard fault not presented.");
  a_tick_calib: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    tick_calibration_out == 16'h2328)
    else $error("Tick calibration value wrong.");

  // Presence of a grant and the idle encoding that the core sees between requests.
  a_valid_tracks: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    (|chan_pend || reset_entry_in || fault_in) |=> grant_valid_out)
    else $error("Pending request not granted.");
  a_idle_none: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    !(|chan_pend) && core_req_in == '0
    && !reset_entry_in && !clock_security_monitor_in && !fault_in
    |=> !grant_valid_out && grant_rank_out == RANK_IDLE && grant_vector_out == VEC_NONE)
    else $error("Idle arbiter still presents a grant.");
  a_masked_quiet: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    chan_enable_in == '0 && core_req_in == '0
    && !reset_entry_in && !clock_security_monitor_in && !fault_in
    |=> !grant_valid_out)
    else $error("Disabled channel reached the core.");
  a_valid_rank: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    grant_valid_out |-> grant_rank_out != RANK_IDLE)
    else $error("Valid grant carries the idle rank.");

  // Channel numbering and the reserved top channels.
  a_reserved_idle: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    chan_pend[31:30] == 2'h0)
    else $error("Reserved channel pending.");
  a_chan_vector: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    grant_valid_out && grant_vector_out >= VEC_CHAN_BASE
    |-> grant_vector_out[1:0] == 2'h0 && grant_vector_out < 32'h0000_00B8)
    else $error("Channel vector out of range.");
  a_chan_rank: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    grant_valid_out && grant_vector_out >= VEC_CHAN_BASE
    |-> grant_rank_out >= RANK_PROG_BASE)
    else $error("Channel grant carries a fixed rank.");

  // Core exceptions sit ahead of every channel, so level 0 lets them through unless a fixed entry or an earlier-scanned core exception pends.
  a_supervisor_vec: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    core_req_in.supervisor_call_entry && supervisor_prio_in == 2'h0
    && !reset_entry_in && !clock_security_monitor_in && !fault_in
    |=> grant_vector_out == VEC_SUPERVISOR)
    else $error("Supervisor call not presented.");
  a_deferred_vec: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    core_req_in.deferred_service_entry && deferred_prio_in == 2'h0
    && !core_req_in.supervisor_call_entry
    && !reset_entry_in && !clock_security_monitor_in && !fault_in
    |=> grant_vector_out == VEC_DEFERRED)
    else $error("Deferred service not presented.");
  a_tick_vec: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    core_req_in.tick_timer_entry && tick_prio_in == 2'h0
    && !core_req_in.supervisor_call_entry && !core_req_in.deferred_service_entry
    && !reset_entry_in && !clock_security_monitor_in && !fault_in
    |=> grant_vector_out == VEC_TICK)
    else $error("Tick timer entry not presented.");
  a_watchdog_vec: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    chan_pend[CHAN_WATCHDOG] && chan_prio_in[1:0] == 2'h0 && core_req_in == '0
    && !reset_entry_in && !clock_security_monitor_in && !fault_in
    |=> grant_vector_out == VEC_CHAN_BASE)
    else $error("Watchdog request not presented.");
  a_tie_lower: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    chan_pend[0] && chan_pend[1] && chan_prio_in[1:0] == chan_prio_in[3:2]
    && !reset_entry_in && !clock_security_monitor_in && !fault_in
    && core_req_in == '0 && chan_prio_in[1:0] == 2'h0
    |=> grant_vector_out == 32'h0000_0040)
    else $error("Tie not resolved to lower channel.");
  a_prio_order: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    chan_pend[0] && chan_pend[1] && chan_prio_in[3:2] == 2'h0 && chan_prio_in[1:0] == 2'h3
    && !reset_entry_in && !clock_security_monitor_in && !fault_in && core_req_in == '0
    |=> grant_vector_out == 32'h0000_0044)
    else $error("Higher priority channel lost.");

  // Every source of a shared channel must raise that channel on its own.
  a_merge_supply: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    merged_in.supply_voltage_detector_request && chan_enable_in[CHAN_SUPPLY]
    |-> chan_pend[CHAN_SUPPLY])
    else $error("Supply detector request lost.");
  a_merge_rtc: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    merged_in.rtc_event_line && chan_enable_in[CHAN_RTC]
    |-> chan_pend[CHAN_RTC])
    else $error("Real-time clock event line lost.");
  a_merge_dma: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    merged_in.dma_channel_request[2] && chan_enable_in[CHAN_DMA_PAIR]
    |-> chan_pend[CHAN_DMA_PAIR])
    else $error("Paired DMA request lost.");
  a_merge_quad: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    merged_in.dma_channel_request[6] && chan_enable_in[CHAN_DMA_QUAD]
    |-> chan_pend[CHAN_DMA_QUAD])
    else $error("Grouped DMA request lost.");
  a_merge_conv: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    merged_in.comparator_event_line != 3'h0 && chan_enable_in[CHAN_CONV_CMP]
    |-> chan_pend[CHAN_CONV_CMP])
    else $error("Comparator event line lost.");
  a_merge_timer: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    merged_in.advanced_timer_general_request != 4'h0 && chan_enable_in[CHAN_TIM_GEN]
    |-> chan_pend[CHAN_TIM_GEN])
    else $error("Timer general request lost.");

  c_reset_taken: cover property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    grant_vector_out == VEC_RESET);
  c_late_higher: cover property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    grant_valid_out ##1 grant_valid_out && grant_rank_out < $past(grant_rank_out));
  c_channel_grant: cover property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    grant_valid_out && grant_vector_out == 32'h0000_0070);
  c_fault_taken: cover property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    grant_valid_out && grant_rank_out == RANK_HARD_FAULT);
  c_core_grant: cover property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    grant_valid_out && grant_vector_out == VEC_TICK);
endmodule : nested_request_arbiter
`default_nettype wire

// File: rtl/vector_map_pkg.sv
// Purpose: Shared constants and carriers for the nested request arbiter.
// Assumes: One 20 MHz system clock; vector addresses are byte addresses.
// Notes: Fixed exception urgencies are encoded below the four programmable levels.
package vector_map_pkg;
  localparam int CHAN_COUNT = 32;
  localparam int LIVE_CHANNELS = 30;
  localparam int PRIO_W = 2;
  localparam int RANK_W = 3;
  localparam logic [31:0] VEC_RESET = 32'h0000_0004;
  localparam logic [31:0] VEC_NONMASK = 32'h0000_0008;
  localparam logic [31:0] VEC_HARD_FAULT = 32'h0000_000C;
  localparam logic [31:0] VEC_SUPERVISOR = 32'h0000_002C;
  localparam logic [31:0] VEC_DEFERRED = 32'h0000_0038;
  localparam logic [31:0] VEC_TICK = 32'h0000_003C;
  localparam logic [31:0] VEC_CHAN_BASE = 32'h0000_0040;
  localparam logic [31:0] VEC_NONE = 32'h0000_0000;
  // Rank 0 is the most urgent; fixed levels -3, -2, -1 map to 0, 1, 2.
  localparam logic [RANK_W-1:0] RANK_RESET = 3'h0;
  localparam logic [RANK_W-1:0] RANK_NONMASK = 3'h1;
  localparam logic [RANK_W-1:0] RANK_HARD_FAULT = 3'h2;
  localparam logic [RANK_W-1:0] RANK_PROG_BASE = 3'h3;
  localparam logic [RANK_W-1:0] RANK_IDLE = 3'h7;
  localparam logic [PRIO_W-1:0] PRIO_RESET_VALUE = 2'h0;
  localparam logic [15:0] TICK_CALIBRATION = 16'h2328;
  localparam int CHAN_WATCHDOG = 0;
  localparam int CHAN_SUPPLY = 1;
  localparam int CHAN_RTC = 2;
  localparam int CHAN_DMA1 = 9;
  localparam int CHAN_DMA_PAIR = 10;
  localparam int CHAN_DMA_QUAD = 11;
  localparam int CHAN_CONV_CMP = 12;
  localparam int CHAN_TIM_GEN = 13;
  localparam int CHAN_TIM_CAP = 14;

  typedef struct packed {
    logic supervisor_call_entry;
    logic deferred_service_entry;
    logic tick_timer_entry;
  } core_req_s;

  typedef struct packed {
    logic supply_voltage_detector_request;
    logic rtc_request;
    logic rtc_event_line;
    logic [6:0] dma_channel_request;
    logic converter_request;
    logic [2:0] comparator_event_line;
    logic [3:0] advanced_timer_general_request;
    logic advanced_timer_capture_request;
  } merged_src_s;

  typedef struct packed {
    logic valid;
    logic [RANK_W-1:0] rank;
    logic [31:0] vector;
  } grant_s;

  function automatic logic [31:0] chan_vector(input logic [4:0] chan);
    chan_vector = VEC_CHAN_BASE + {25'h0, chan, 2'h0};
  endfunction : chan_vector
endpackage : vector_map_pkg

// File: rtl/request_merge.sv
// Purpose: Folds grouped peripheral sources onto their shared request channels.
// Assumes: All sources are on the system clock and already synchronised.
// Notes: Pure combinational; unmerged channels below 30 pass straight through; channels 30 and 31 are cleared.
`timescale 1ns/1ps
`default_nettype none
module request_merge
  import vector_map_pkg::*;
(
  input wire logic [CHAN_COUNT-1:0] direct_req_in,
  input wire merged_src_s merged_in,
  output logic [CHAN_COUNT-1:0] chan_req_out
);
  always_comb begin
    chan_req_out = direct_req_in;
    chan_req_out[CHAN_SUPPLY] = merged_in.supply_voltage_detector_request;
    chan_req_out[CHAN_RTC] = merged_in.rtc_request | merged_in.rtc_event_line;
    chan_req_out[CHAN_DMA1] = merged_in.dma_channel_request[0];
    chan_req_out[CHAN_DMA_PAIR] = |merged_in.dma_channel_request[2:1];
    chan_req_out[CHAN_DMA_QUAD] = |merged_in.dma_channel_request[6:3];
    chan_req_out[CHAN_CONV_CMP] = merged_in.converter_request
        | (|merged_in.comparator_event_line);
    chan_req_out[CHAN_TIM_GEN] = |merged_in.advanced_timer_general_request;
    chan_req_out[CHAN_TIM_CAP] = merged_in.advanced_timer_capture_request;
    chan_req_out[CHAN_COUNT-1:LIVE_CHANNELS] = '0;
  end
endmodule : request_merge
`default_nettype wire

// File: test/core_model.sv
// Purpose: Core side that holds its own exception requests until they are taken.
// Assumes: An exception is taken in the cycle its vector is offered.
// Notes: Taking at once keeps the arbiter busy with fresh requests.
`timescale 1ns/1ps
`default_nettype none
module core_model
  import vector_map_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  input wire core_req_s raise_in,
  input wire logic grant_valid_in,
  input wire logic [31:0] grant_vector_in,
  output core_req_s core_req_out
);
  core_req_s taken;
  assign taken = {grant_valid_in && grant_vector_in === 32'h0000_002C,
                  grant_valid_in && grant_vector_in === 32'h0000_0038,
                  grant_valid_in && grant_vector_in === 32'h0000_003C};
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      core_req_out <= '0;
    end else begin
      core_req_out <= (core_req_out & ~taken) | raise_in;
    end
  end
endmodule : core_model
`default_nettype wire

// File: test/tb_nested_request_arbiter.sv
// Purpose: Compares every grant of the arbiter with a behavioural model.
// Assumes: The grant follows the inputs sampled at the previous edge.
// Notes: Directed sweeps first, then random traffic with a reset mid-run.
`timescale 1ns/1ps
`default_nettype none
module tb_nested_request_arbiter;
  import vector_map_pkg::*;
  logic clk_sys_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic rst_e = 1'b0;
  logic nmi = 1'b0;
  logic fault = 1'b0;
  core_req_s raise = '0;
  core_req_s core_req;
  logic [1:0] sup_p = 2'h0;
  logic [1:0] def_p = 2'h0;
  logic [1:0] tick_p = 2'h0;
  logic [31:0] dreq = 32'h0;
  merged_src_s m = '0;
  logic [31:0] en = 32'h0;
  logic [63:0] cprio = 64'h0;
  logic gv;
  logic [2:0] gr;
  logic [31:0] gvec;
  logic [15:0] cal;
  logic [35:0] exp_g;
  int bad_count = 0;
  int comparisons = 0;
  always #25 clk_sys_in = ~clk_sys_in;
  core_model core_model_i (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .raise_in(raise),
    .grant_valid_in(gv), .grant_vector_in(gvec), .core_req_out(core_req));
  nested_request_arbiter nested_request_arbiter_i (.clk_sys_in(clk_sys_in),
    .reset_n_in(reset_n_in), .reset_entry_in(rst_e), .clock_security_monitor_in(nmi),
    .fault_in(fault), .core_req_in(core_req), .supervisor_prio_in(sup_p),
    .deferred_prio_in(def_p), .tick_prio_in(tick_p), .direct_req_in(dreq), .merged_in(m),
    .chan_enable_in(en), .chan_prio_in(cprio), .grant_valid_out(gv), .grant_rank_out(gr),
    .grant_vector_out(gvec), .tick_calibration_out(cal));
  function automatic logic [35:0] expect_grant();
    logic [31:0] req;
    logic [32:0] pend;
    int best;
    int p;
    logic [31:0] vec;
    best = 9;
    vec = 32'h0;
    if (rst_e) return {1'b1, 3'h0, 32'h0000_0004};
    if (nmi) return {1'b1, 3'h1, 32'h0000_0008};
    if (fault) return {1'b1, 3'h2, 32'h0000_000C};
    req = dreq;
    req[1] = m.supply_voltage_detector_request;
    req[2] = m.rtc_request | m.rtc_event_line;
    req[9] = m.dma_channel_request[0];
    req[10] = |m.dma_channel_request[2:1];
    req[11] = |m.dma_channel_request[6:3];
    req[12] = m.converter_request | (|m.comparator_event_line);
    req[13] = |m.advanced_timer_general_request;
    req[14] = m.advanced_timer_capture_request;
    req = req & en & 32'h3FFF_FFFF;
    pend = {req, 1'b0} << 2 | 33'({core_req.tick_timer_entry, core_req.deferred_service_entry,
      core_req.supervisor_call_entry});
    for (int i = 0; i < 33; i++) begin
      p = (i == 0) ? sup_p : (i == 1) ? def_p : (i == 2) ? tick_p : cprio[2*(i>2?i-3:0) +: 2];
      if (pend[i] && p < best) begin
        best = p;
        vec = (i == 0) ? 32'h2C : (i == 1) ? 32'h38 : (i == 2) ? 32'h3C : 32'h40 + 4 * (i - 3);
      end
    end
    if (best == 9) return {1'b0, 3'h7, 32'h0};
    return {1'b1, 3'(best + 3), vec};
  endfunction : expect_grant
  task automatic check(input logic [35:0] seen, input logic [35:0] want);
    comparisons++;
    if (seen !== want) begin
      bad_count++;
      $display("MISMATCH %0t seen %h want %h", $time, seen, want);
    end
  endtask : check
  task automatic stop_test();
    if (bad_count == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : stop_test
  task automatic step();
    @(posedge clk_sys_in);
    #1;
  endtask : step
  always @(posedge clk_sys_in or negedge reset_n_in) begin
    exp_g <= reset_n_in ? expect_grant() : {1'b0, 3'h7, 32'h0};
  end
  always @(negedge clk_sys_in) begin
    check({gv, gr, gvec}, exp_g);
    check(36'(cal), 36'd9000);
  end
  initial begin
    void'($urandom(32'h37939C20));
    repeat (4) step();
    reset_n_in = 1'b1;
    en = 32'hFFFF_FFFF;
    dreq = 32'hC000_0000;
    step();
    // One source at a time walks every channel and every merged source.
    for (int i = 0; i < 51; i++) begin
      dreq = (i < 32) ? 32'h1 << i : 32'h0;
      m = merged_src_s'((i < 32) ? 19'h0 : 19'h1 << (i - 32));
      step();
    end
    // Watchdog and supply detector pend together: a tie first, then the supply more urgent.
    dreq = 32'h1;
    m = merged_src_s'(19'h4_0000);
    step();
    cprio = 64'h3;
    step();
    for (int n = 0; n < 3000; n++) begin
      step();
      reset_n_in = !(n >= 1500 && n < 1502);
      rst_e = ($urandom % 40) == 0;
      nmi = ($urandom % 40) == 0;
      fault = ($urandom % 40) == 0;
      raise = core_req_s'(3'($urandom & $urandom));
      {sup_p, def_p, tick_p} = 6'($urandom);
      dreq = $urandom & $urandom & $urandom;
      m = merged_src_s'(19'($urandom & $urandom & $urandom));
      en = $urandom | $urandom;
      cprio = (n % 4 == 0) ? 64'h0 : {$urandom, $urandom};
    end
    step();
    stop_test();
  end
  initial begin
    #(4000 * 50);
    bad_count++;
    stop_test();
  end
endmodule : tb_nested_request_arbiter
`default_nettype wire
